// ===== design/ccw_core.sv
// Execute logic for subroutine call, clear register and watchdog clear
`timescale 1ns/100ps
//
// Contract
// RULE1 - Call pushes PC+4 onto the return stack before PC changes.
// RULE2 - Fast-save bit 1 copies working, status, bank select into shadows.
// RULE3 - Fast-save bit 0 leaves all three shadows unchanged.
// RULE4 - 20-bit target goes into PC bits 20:1, bit 0 stays zero.
// RULE5 - Call reaches any word of the two-megabyte program space.
// RULE6 - Call takes two cycles; the second is a no-operation refill.
// RULE7 - Call is two words: opcode, s, k7:0 then all-ones prefix, k19:8.
// RULE8 - Clear writes zero to the register, sets Z, no other flag.
// RULE9 - Access bit 0 addresses the fixed access bank.
// RULE10 - Access bit 1 forms address from bank select and operand.
// RULE11 - Extended set, access 0, operand at most 5Fh: indexed literal offset.
// RULE12 - Watchdog-clear opcode zeroes watchdog counter and postscaler.
// RULE13 - Watchdog clear sets timeout and power-down flags to 1.
// RULE14 - Clear and watchdog clear finish in one four-phase cycle.
module ccw_core
   import ccw_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic                    hreadyout,
   output logic                    hresp,
   output logic      [31:0]        hrdata,
   input  wire logic               instrValid,
   input  wire logic [15:0]        instrWord,
   input  wire logic [15:0]        instrNextWord,
   input  wire logic [PC_W-1:0]    pcCurrent,
   input  wire logic [DADDR_W-1:0] indexBase,
   output logic      [1:0]         phaseQ,
   output logic                    fetchFlush,
   output logic                    pcLoad,
   output logic      [PC_W-1:0]    pcTarget,
   output logic                    stackPush,
   output logic      [PC_W-1:0]    stackTopEntry,
   output logic                    dmemWrEn,
   output logic      [DADDR_W-1:0] dmemAddr,
   output logic      [7:0]         dmemWrData,
   output logic                    watchdogClear,
   output logic                    postscalerClear,
   output logic                    timeoutFlagN,
   output logic                    powerdownFlagN
);
   // ********************************************************************
   // Declarations
   // ********************************************************************
   ccw_state_t         state_r;
   ccw_op_t            op_r;
   ccw_op_t            decOp;
   logic [1:0]         qPhase_r;
   logic               decMode;
   logic [7:0]         decOperand;
   logic               modeBit_r;
   logic [7:0]         operand_r;
   logic [PC_W-1:0]    callPc_r;
   logic [DADDR_W-1:0] genAddr;
   logic               decodeNow;
   logic               shadowCopy;
   logic [7:0]         workingReg_r;
   logic [4:0]         statusReg_r;
   logic [BANK_W-1:0]  bankSelectReg_r;
   logic [7:0]         workingShadow_r;
   logic [4:0]         flagsShadow_r;
   logic [BANK_W-1:0]  bankSelectShadow_r;
   logic               extEnable_r;
   logic               fetchFlush_r;
   logic               pcLoad_r;
   logic [PC_W-1:0]    pcTarget_r;
   logic               stackPush_r;
   logic [PC_W-1:0]    stackTopEntry_r;
   logic               dmemWrEn_r;
   logic [DADDR_W-1:0] dmemAddr_r;
   logic [7:0]         dmemWrData_r;
   logic               watchdogClear_r;
   logic               postscalerClear_r;
   logic               timeoutFlagN_r;
   logic               powerdownFlagN_r;
   logic               busAccept;
   logic               busWrite;
   logic               wrPend_r;
   logic [7:0]         wrAddr_r;
   logic [31:0]        hrdata_r;
   logic               hreadyout_r;
   logic               hresp_r;

   // ********************************************************************
   // Decode and address forming
   // ********************************************************************
   ccw_decode u_decode (
      .instrWord  (instrWord),
      .opKind     (decOp),
      .modeBit    (decMode),
      .operandLow (decOperand)
   );

   ccw_addr_gen u_addr_gen (
      .fileOp    (operand_r),
      .accessBit (modeBit_r),
      .bankSel   (bankSelectReg_r),
      .extEnable (extEnable_r),
      .indexBase (indexBase),
      .dataAddr  (genAddr)
   );

   // Refill cycle never decodes: the word on the bus is stale
   assign decodeNow  = (qPhase_r == Q1_DECODE) && (state_r == ST_RUN) && instrValid;
   assign shadowCopy = (op_r == OP_CALL) && (qPhase_r == Q3_PROCESS) && modeBit_r;

   // ********************************************************************
   // Phase counter and sequencing
   // ********************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         qPhase_r <= 2'h0;
      end else begin
         qPhase_r <= qPhase_r + 2'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_RUN;
      end else if (qPhase_r == Q4_WRITE) begin
         case (state_r)
            ST_RUN: begin
               if (op_r == OP_CALL) begin
                  state_r <= ST_REFILL;                         // see RULE6
               end
            end
            ST_REFILL: begin
               state_r <= ST_RUN;
            end
            default: begin
               state_r <= ST_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         op_r      <= OP_NONE;
         modeBit_r <= 1'b0;
         operand_r <= 8'h00;
         callPc_r  <= '0;
      end else if (decodeNow) begin
         op_r      <= decOp;                                    // see RULE7
         modeBit_r <= decMode;
         operand_r <= decOperand;
         callPc_r  <= pcCurrent;
      end else if (qPhase_r == Q4_WRITE) begin
         op_r <= OP_NONE;
      end
   end

   // ********************************************************************
   // Call: push, shadows, program counter
   // ********************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stackPush_r     <= 1'b0;
         stackTopEntry_r <= '0;
      end else begin
         stackPush_r <= (op_r == OP_CALL) && (qPhase_r == Q3_PROCESS);
         if ((op_r == OP_CALL) && (qPhase_r == Q3_PROCESS)) begin
            stackTopEntry_r <= callPc_r + RET_STEP;             // see RULE1
         end
      end
   end

   // Shadows are read-only to software so they only move on a fast call
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         workingShadow_r    <= WORKING_RST;
         flagsShadow_r      <= STATUS_RST;
         bankSelectShadow_r <= BANK_RST;
      end else if (shadowCopy) begin
         workingShadow_r    <= workingReg_r;                    // see RULE2
         flagsShadow_r      <= statusReg_r;                     // see RULE2
         bankSelectShadow_r <= bankSelectReg_r;                 // see RULE2, see RULE3
      end
   end

   // Second word is read at Q4; prefix is not checked, bits 11:0 are used
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pcLoad_r     <= 1'b0;
         fetchFlush_r <= 1'b0;
         pcTarget_r   <= '0;
      end else begin
         pcLoad_r     <= (op_r == OP_CALL) && (qPhase_r == Q4_WRITE);
         fetchFlush_r <= (op_r == OP_CALL) && (qPhase_r == Q4_WRITE); // see RULE6
         if ((op_r == OP_CALL) && (qPhase_r == Q4_WRITE)) begin
            pcTarget_r <= {instrNextWord[11:0], operand_r, 1'b0}; // see RULE4, see RULE5
         end
      end
   end

   // ********************************************************************
   // Clear register
   // ********************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dmemWrEn_r   <= 1'b0;
         dmemAddr_r   <= '0;
         dmemWrData_r <= 8'h00;
      end else begin
         dmemWrEn_r <= (op_r == OP_ZERO) && (qPhase_r == Q4_WRITE); // see RULE14
         if ((op_r == OP_ZERO) && (qPhase_r == Q4_WRITE)) begin
            dmemAddr_r   <= genAddr;
            dmemWrData_r <= 8'h00;                              // see RULE8
         end
      end
   end

   // ********************************************************************
   // Watchdog clear
   // ********************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         watchdogClear_r   <= 1'b0;
         postscalerClear_r <= 1'b0;
      end else begin
         watchdogClear_r   <= (op_r == OP_KICK) && (qPhase_r == Q3_PROCESS); // see RULE12
         postscalerClear_r <= (op_r == OP_KICK) && (qPhase_r == Q3_PROCESS); // see RULE12
      end
   end

   // Set wins over a software clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timeoutFlagN_r   <= RSTAT_RST[RSTAT_TMOUT_BIT];
         powerdownFlagN_r <= RSTAT_RST[RSTAT_PDOWN_BIT];
      end else if ((op_r == OP_KICK) && (qPhase_r == Q3_PROCESS)) begin
         timeoutFlagN_r   <= 1'b1;                              // see RULE13
         powerdownFlagN_r <= 1'b1;                              // see RULE13
      end else if (busWrite && (wrAddr_r == OFF_RST_STATUS)) begin
         timeoutFlagN_r   <= hwdata[RSTAT_TMOUT_BIT];
         powerdownFlagN_r <= hwdata[RSTAT_PDOWN_BIT];
      end
   end

   // ********************************************************************
   // AHB-Lite slave
   // ********************************************************************
   assign busAccept = hsel && htrans[1] && hready;
   assign busWrite  = wrPend_r;

   function automatic logic [31:0] regRead(input logic [7:0] offset);
      logic [31:0] value;
      value = 32'h0000_0000;
      if (offset == OFF_CTRL) begin
         value[CTRL_EXT_BIT] = extEnable_r;
      end else if (offset == OFF_WORKING) begin
         value[7:0] = workingReg_r;
      end else if (offset == OFF_STATUS) begin
         value[4:0] = statusReg_r;
      end else if (offset == OFF_BANK_SEL) begin
         value[BANK_W-1:0] = bankSelectReg_r;
      end else if (offset == OFF_WORK_SHADOW) begin
         value[7:0] = workingShadow_r;
      end else if (offset == OFF_FLAG_SHADOW) begin
         value[4:0] = flagsShadow_r;
      end else if (offset == OFF_BANK_SHADOW) begin
         value[BANK_W-1:0] = bankSelectShadow_r;
      end else if (offset == OFF_STACK_TOP) begin
         value[PC_W-1:0] = stackTopEntry_r;
      end else if (offset == OFF_RST_STATUS) begin
         value[RSTAT_TMOUT_BIT] = timeoutFlagN_r;
         value[RSTAT_PDOWN_BIT] = powerdownFlagN_r;
      end else if (offset == OFF_PC_TARGET) begin
         value[PC_W-1:0] = pcTarget_r;
      end
      return value;
   endfunction

   // Narrow writes are dropped; only whole words reach a register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPend_r    <= 1'b0;
         wrAddr_r    <= 8'h00;
         hrdata_r    <= 32'h0000_0000;
         hreadyout_r <= 1'b1;
         hresp_r     <= 1'b0;
      end else begin
         wrPend_r <= busAccept && hwrite && (hsize == HSIZE_WORD);
         if (busAccept) begin
            wrAddr_r <= haddr[7:0];
         end
         hrdata_r    <= (busAccept && !hwrite) ? regRead(haddr[7:0]) : 32'h0000_0000;
         hreadyout_r <= 1'b1;
         hresp_r     <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         workingReg_r    <= WORKING_RST;
         bankSelectReg_r <= BANK_RST;
         extEnable_r     <= 1'b0;
      end else if (busWrite) begin
         if (wrAddr_r == OFF_WORKING) begin
            workingReg_r <= hwdata[7:0];
         end else if (wrAddr_r == OFF_BANK_SEL) begin
            bankSelectReg_r <= hwdata[BANK_W-1:0];
         end else if (wrAddr_r == OFF_CTRL) begin
            extEnable_r <= hwdata[CTRL_EXT_BIT];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         statusReg_r <= STATUS_RST;
      end else begin
         if (busWrite && (wrAddr_r == OFF_STATUS)) begin
            statusReg_r <= hwdata[4:0];
         end
         if ((op_r == OP_ZERO) && (qPhase_r == Q4_WRITE)) begin
            statusReg_r[STATUS_Z_BIT] <= 1'b1;                  // see RULE8
         end
      end
   end

   // ********************************************************************
   // Outputs
   // ********************************************************************
   assign hreadyout       = hreadyout_r;
   assign hresp           = hresp_r;
   assign hrdata          = hrdata_r;
   assign phaseQ          = qPhase_r;
   assign fetchFlush      = fetchFlush_r;
   assign pcLoad          = pcLoad_r;
   assign pcTarget        = pcTarget_r;
   assign stackPush       = stackPush_r;
   assign stackTopEntry   = stackTopEntry_r;
   assign dmemWrEn        = dmemWrEn_r;
   assign dmemAddr        = dmemAddr_r;
   assign dmemWrData      = dmemWrData_r;
   assign watchdogClear   = watchdogClear_r;
   assign postscalerClear = postscalerClear_r;
   assign timeoutFlagN    = timeoutFlagN_r;
   assign powerdownFlagN  = powerdownFlagN_r;

   // ********************************************************************
   // Assertions
   // ********************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   push_value_a: assert property ( // see RULE1
      stackPush_r |-> (stackTopEntry_r == callPc_r + RET_STEP) ##1 pcLoad_r)
      else $error("Return address wrong or pushed after PC load");

   shadow_copy_a: assert property ( // see RULE2
      shadowCopy |=> (workingShadow_r == $past(workingReg_r))
                     && (flagsShadow_r == $past(statusReg_r))
                     && (bankSelectShadow_r == $past(bankSelectReg_r)))
      else $error("Fast call did not copy into shadows");

   shadow_keep_a: assert property ( // see RULE3
      !shadowCopy |=> $stable(workingShadow_r) && $stable(flagsShadow_r)
                      && $stable(bankSelectShadow_r))
      else $error("Shadow changed without a fast call");

   call_target_a: assert property ( // see RULE4, see RULE5
      pcLoad_r |-> pcTarget_r == {$past(instrNextWord[11:0]), operand_r, 1'b0})
      else $error("Call target not placed in PC bits 20:1");

   call_refill_a: assert property ( // see RULE6
      pcLoad_r |-> (state_r == ST_REFILL && !stackPush_r && !dmemWrEn_r
                    && !watchdogClear_r)[*4] ##1 (state_r == ST_RUN))
      else $error("Refill cycle not a four-phase no-operation");

   call_decode_a: assert property ( // see RULE7
      (decodeNow && instrWord[15:9] == CALL_OPC) |=> (op_r == OP_CALL)
         && (modeBit_r == $past(instrWord[8])) && (operand_r == $past(instrWord[7:0])))
      else $error("First call word decoded wrongly");

   zero_write_a: assert property ( // see RULE8
      dmemWrEn_r |-> (dmemWrData_r == 8'h00) && statusReg_r[STATUS_Z_BIT])
      else $error("Clear did not write zero and set Z");

   access_bank_a: assert property ( // see RULE9
      (dmemWrEn_r && !modeBit_r && !$past(extEnable_r)) |->
         dmemAddr_r == {((operand_r < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK),
                        operand_r})
      else $error("Access bank address wrong");

   banked_addr_a: assert property ( // see RULE10
      (dmemWrEn_r && modeBit_r) |-> dmemAddr_r == {$past(bankSelectReg_r), operand_r})
      else $error("Banked address wrong");

   indexed_addr_a: assert property ( // see RULE11
      (dmemWrEn_r && !modeBit_r && $past(extEnable_r) && operand_r <= LITERAL_MAX) |->
         dmemAddr_r == $past(indexBase) + {4'h0, operand_r})
      else $error("Indexed literal offset address wrong");

   kick_clear_a: assert property ( // see RULE12
      (decodeNow && decOp == OP_KICK) |-> ##3 (watchdogClear_r && postscalerClear_r)
         ##1 !watchdogClear_r)
      else $error("Watchdog clear pulse missing or late");

   kick_flags_a: assert property ( // see RULE13
      watchdogClear_r |-> timeoutFlagN_r && powerdownFlagN_r)
      else $error("Flags not set by watchdog clear");

   zero_timing_a: assert property ( // see RULE14
      (decodeNow && decOp == OP_ZERO) |-> ##4 dmemWrEn_r ##1 !dmemWrEn_r)
      else $error("Clear did not finish in one instruction cycle");

   fast_call_c: cover property (decodeNow && decOp == OP_CALL && decMode);
   plain_call_c: cover property (decodeNow && decOp == OP_CALL && !decMode);
   zero_op_c: cover property (decodeNow && decOp == OP_ZERO);
   kick_op_c: cover property (decodeNow && decOp == OP_KICK);
endmodule // ccw_core

// ===== design/ccw_pkg.sv
// Constants and types shared by the call, clear and watchdog-clear decoder
package ccw_pkg;
   // ********************************************************************
   // Widths and phases
   // ********************************************************************
   localparam int         PC_W        = 21;
   localparam int         DADDR_W     = 12;
   localparam int         BANK_W      = 4;
   localparam logic [1:0] Q1_DECODE   = 2'h0;
   localparam logic [1:0] Q3_PROCESS  = 2'h2;
   localparam logic [1:0] Q4_WRITE    = 2'h3;

   // ********************************************************************
   // Opcodes and addressing
   // ********************************************************************
   localparam logic [6:0]      CALL_OPC         = 7'h76;
   localparam logic [6:0]      ZERO_OPC         = 7'h35;
   localparam logic [3:0]      CALL2_PREFIX     = 4'hF;
   localparam logic [15:0]     KICK_OPC         = 16'h0004;
   localparam logic [7:0]      ACCESS_SPLIT     = 8'h60;
   localparam logic [7:0]      LITERAL_MAX      = 8'h5F;
   localparam logic [3:0]      ACCESS_LOW_BANK  = 4'h0;
   localparam logic [3:0]      ACCESS_HIGH_BANK = 4'hF;
   localparam logic [PC_W-1:0] RET_STEP         = 21'h000004;
   localparam int              STATUS_Z_BIT     = 2;

   // ********************************************************************
   // Register map and reset values
   // ********************************************************************
   localparam logic [7:0] OFF_CTRL        = 8'h00;
   localparam logic [7:0] OFF_WORKING     = 8'h04;
   localparam logic [7:0] OFF_STATUS      = 8'h08;
   localparam logic [7:0] OFF_BANK_SEL    = 8'h0C;
   localparam logic [7:0] OFF_WORK_SHADOW = 8'h10;
   localparam logic [7:0] OFF_FLAG_SHADOW = 8'h14;
   localparam logic [7:0] OFF_BANK_SHADOW = 8'h18;
   localparam logic [7:0] OFF_STACK_TOP   = 8'h1C;
   localparam logic [7:0] OFF_RST_STATUS  = 8'h20;
   localparam logic [7:0] OFF_PC_TARGET   = 8'h24;
   localparam int         CTRL_EXT_BIT    = 0;
   localparam int         RSTAT_PDOWN_BIT = 0;
   localparam int         RSTAT_TMOUT_BIT = 1;
   localparam logic [7:0] WORKING_RST     = 8'h00;
   localparam logic [4:0] STATUS_RST      = 5'h00;
   localparam logic [3:0] BANK_RST        = 4'h0;
   localparam logic [1:0] RSTAT_RST       = 2'h3;
   localparam logic [2:0] HSIZE_WORD      = 3'h2;

   typedef enum logic [0:0] {ST_RUN = 1'b0, ST_REFILL = 1'b1} ccw_state_t;
   typedef enum logic [1:0] {
      OP_NONE = 2'b00, OP_CALL = 2'b01, OP_ZERO = 2'b10, OP_KICK = 2'b11
   } ccw_op_t;
endpackage

// ===== design/ccw_decode.sv
// Instruction word classifier for call, clear-register and watchdog-clear
`timescale 1ns/100ps
module ccw_decode
   import ccw_pkg::*;
(
   input  wire logic [15:0] instrWord,
   output ccw_op_t          opKind,
   output logic             modeBit,
   output logic [7:0]       operandLow
);
   // ********************************************************************
   // Classify
   // ********************************************************************
   always_comb begin
      if (instrWord[15:9] == CALL_OPC) begin
         opKind = OP_CALL;
      end else if (instrWord[15:9] == ZERO_OPC) begin
         opKind = OP_ZERO;
      end else if (instrWord == KICK_OPC) begin
         opKind = OP_KICK;
      end else begin
         opKind = OP_NONE;
      end
   end

   // Fast-save and access bit share one position
   assign modeBit    = instrWord[8];
   assign operandLow = instrWord[7:0];
endmodule // ccw_decode

// ===== design/ccw_addr_gen.sv
// Data address former for the clear-register operation
`timescale 1ns/100ps
module ccw_addr_gen
   import ccw_pkg::*;
(
   input  wire logic [7:0]         fileOp,
   input  wire logic               accessBit,
   input  wire logic [BANK_W-1:0]  bankSel,
   input  wire logic               extEnable,
   input  wire logic [DADDR_W-1:0] indexBase,
   output logic      [DADDR_W-1:0] dataAddr
);
   // ********************************************************************
   // Address modes
   // ********************************************************************
   always_comb begin
      if (accessBit) begin
         dataAddr = {bankSel, fileOp};                          // see RULE10
      end else if (extEnable && (fileOp <= LITERAL_MAX)) begin
         dataAddr = indexBase + {4'h0, fileOp};                 // see RULE11
      end else if (fileOp < ACCESS_SPLIT) begin
         dataAddr = {ACCESS_LOW_BANK, fileOp};                  // see RULE9
      end else begin
         dataAddr = {ACCESS_HIGH_BANK, fileOp};                 // see RULE9
      end
   end
endmodule // ccw_addr_gen

// ===== verification/ccw_partner_model.sv
// Fetch pipeline and data memory stand-in facing the decoder
`timescale 1ns/100ps
module ccw_partner_model
   import ccw_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               stackPush,
   input  wire logic [PC_W-1:0]    stackTopEntry,
   input  wire logic               pcLoad,
   input  wire logic               fetchFlush,
   input  wire logic [PC_W-1:0]    pcTarget,
   input  wire logic               dmemWrEn,
   input  wire logic [DADDR_W-1:0] dmemAddr,
   input  wire logic [7:0]         dmemWrData,
   input  wire logic               watchdogClear,
   input  wire logic               postscalerClear,
   output logic      [PC_W-1:0]    pushed,
   output logic      [PC_W-1:0]    jumped,
   output logic      [19:0]        wrRec,
   output int                      kicks
);
   initial kicks = 0;
   // Jump only counts when the pipeline is flushed with it
   always @(posedge clk) begin
      if (stackPush) pushed <= stackTopEntry;
      if (pcLoad && fetchFlush) jumped <= pcTarget;
      if (dmemWrEn) wrRec <= {dmemAddr, dmemWrData};
      if (watchdogClear && postscalerClear) kicks <= kicks + 1;
   end
endmodule // ccw_partner_model

// ===== verification/tb_top.sv
// Self-checking bench for the call, clear and watchdog-clear decoder
`timescale 1ns/100ps
module tb_top;
   import ccw_pkg::*;
   logic clk = 0, rst_n = 0, hwrite = 0, instrValid = 0, pcLoad, fetchFlush;
   logic [1:0] htrans = 0, phaseQ;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [15:0] instrWord = 0, instrNextWord = 0;
   logic [PC_W-1:0] pcCurrent = 0, pushed, jumped, pcTarget, stackTopEntry;
   logic [DADDR_W-1:0] indexBase = 0, ea, dmemAddr;
   logic [19:0] wrRec, k;
   logic hreadyout, stackPush, dmemWrEn, wdClr, psClr, hresp, toN, pdN;
   logic [7:0] dmemWrData, wv, sw, f;
   logic [3:0] bank;
   int err_count = 0, comparisons = 0, kicks;
   always #4 clk = ~clk;
   ccw_core DUT (.clk, .rst_n, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(HSIZE_WORD),
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .instrValid, .instrWord,
      .instrNextWord, .pcCurrent, .indexBase, .phaseQ, .fetchFlush, .pcLoad, .pcTarget,
      .stackPush, .stackTopEntry, .dmemWrEn, .dmemAddr, .dmemWrData, .watchdogClear(wdClr),
      .postscalerClear(psClr), .timeoutFlagN(toN), .powerdownFlagN(pdN));
   ccw_partner_model PM (.clk, .stackPush, .stackTopEntry, .pcLoad, .fetchFlush, .pcTarget,
      .dmemWrEn, .dmemAddr, .dmemWrData, .watchdogClear(wdClr), .postscalerClear(psClr),
      .pushed, .jumped, .wrRec, .kicks);
   task automatic end_of_test();
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic waitRdy();
      int n = 0;
      do begin
         @(posedge clk);
         if (++n > 50) begin
            err_count++;
            end_of_test();
         end
      end while (hreadyout !== 1'b1);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      waitRdy();
      htrans <= 2'h0;
      hwdata <= d;
      waitRdy();
      rd = hrdata;
      chk(32'(hresp), 32'h0);
   endtask
   // Lines up the request so the next phase-zero edge takes it
   task automatic issue(input logic [15:0] w, input logic [15:0] nw);
      @(negedge clk);
      repeat (3) if (phaseQ !== Q4_WRITE) @(negedge clk);
      @(posedge clk);
      instrValid <= 1'b1;
      instrWord <= w;
      instrNextWord <= nw;
      @(posedge clk);
      instrValid <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   initial begin
      k = 20'($urandom(32'h44A5));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, OFF_RST_STATUS, 0);
      chk(rd, 32'h3);
      bus(1'b0, 8'h40, 0);
      chk(rd, 32'h0);
      for (int i = 1; i >= 0; i--) begin
         k = 20'($urandom);
         pcCurrent <= 21'($urandom) & 21'h1FFFFE;
         wv = 8'($urandom);
         if (i == 1) sw = wv;
         bus(1'b1, OFF_WORKING, 32'(wv));
         issue({CALL_OPC, i[0], k[7:0]}, {CALL2_PREFIX, k[19:8]});
         chk(32'(pushed), 32'(PC_W'(pcCurrent + RET_STEP)));
         chk(32'(jumped), 32'({k, 1'b0}));
         bus(1'b0, OFF_WORK_SHADOW, 0);
         chk(rd, 32'(sw));
      end
      // Banked, access bank halves, then indexed with the extended set on
      for (int i = 0; i < 4; i++) begin
         bank = 4'($urandom);
         f = (i == 2) ? 8'h60 | 8'($urandom) : 8'($urandom) & 8'h5F;
         indexBase <= 12'($urandom);
         bus(1'b1, OFF_BANK_SEL, 32'(bank));
         bus(1'b1, OFF_CTRL, 32'(i == 3));
         bus(1'b1, OFF_STATUS, 0);
         issue({ZERO_OPC, i == 0, f}, 16'h0);
         ea = (i == 0) ? {bank, f} : (i == 3) ? indexBase + 12'(f) : {(i == 2) ? 4'hF : 4'h0, f};
         chk(32'(wrRec), 32'({ea, 8'h00}));
         bus(1'b0, OFF_STATUS, 0);
         chk(rd, 32'h4);
      end
      bus(1'b1, OFF_RST_STATUS, 0);
      issue(KICK_OPC, 16'h0);
      chk(32'(kicks), 32'h1);
      chk(32'({toN, pdN}), 32'h3);
      bus(1'b0, OFF_RST_STATUS, 0);
      chk(rd, 32'h3);
      // Reset in mid-run must clear the shadow left by the fast call
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, OFF_WORK_SHADOW, 0);
      chk(rd, 32'h0);
      end_of_test();
   end
endmodule // tb_top
